// file: core/hstrp_core.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "hstrp_defines.svh"

module hstrp_core #(
    parameter bit EL3_IMPL = 1'b1,
    parameter bit NV_FEAT = 1'b0,
    parameter bit FGT_FEAT = 1'b0,
    parameter bit NOEL3_TRAP = 1'b1,
    parameter bit COND_FAIL_TRAP = 1'b0,
    parameter bit RAZ_TRAP = 1'b1,
    parameter bit UNLISTED_TRAP = 1'b0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request from instruction decode
    input wire logic req_valid,
    input hstrp_pkg::hstrp_kind_e req_kind,
    input hstrp_pkg::hstrp_el_e req_el,
    input wire logic req_wide,
    input wire logic req_cond_fail,
    input wire logic [1:0] req_op0,
    input wire logic [2:0] req_op1,
    input wire logic [3:0] req_crn,
    input wire logic [3:0] req_crm,
    input wire logic [3:0] req_coproc,
    input hstrp_pkg::hstrp_idcls_e req_id_class,
    input wire logic req_raz,
    input wire logic req_fp_feature,
    input wire logic req_cp_trap,
    // Decision to exception entry
    output logic res_valid,
    output logic res_trap,
    output logic res_undef,
    output logic res_allow,
    output logic res_ret_at_instr,
    output logic [5:0] res_ec
);

    hstrp_pkg::hstrp_state_s s_reg;
    hstrp_pkg::hstrp_state_s s_next;

    logic tsc_eff;
    logic id_group3_trap_bit_eff;
    logic hyp_en;
    logic kernel;
    logic trap;
    logic undef;
    logic [5:0] ec;
    logic in_space;
    logic hit;
    logic [31:0] merged;
    logic [31:0] status;

    // ****************************************************************
    // Trap decision
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        tsc_eff = s_reg.cfg[`HSTRP_CFG_TSC] & ~s_reg.cfg[`HSTRP_CFG_TGE];
        id_group3_trap_bit_eff = s_reg.cfg[`HSTRP_CFG_ID_GROUP3_TRAP_BIT] & ~s_reg.cfg[`HSTRP_CFG_TGE];
        hyp_en = s_reg.cfg[`HSTRP_CFG_HYP_EN];
        kernel = (req_el == hstrp_pkg::HSTRP_EL_KERNEL);
        trap = 1'b0;
        undef = 1'b0;
        ec = `HSTRP_EC_NONE;
        in_space = 1'b0;
        hit = 1'b0;
        // Listed always; newer unless zero-reading with RAZ_TRAP clear; unlisted per UNLISTED_TRAP; fine-grained all
        case (req_id_class)
            hstrp_pkg::HSTRP_ID_LISTED: hit = 1'b1;
            hstrp_pkg::HSTRP_ID_NEWER: hit = !req_raz || RAZ_TRAP;
            default: hit = UNLISTED_TRAP;
        endcase
        hit = hit || FGT_FEAT;
        case (req_kind)
            hstrp_pkg::HSTRP_K_SMC: begin
                ec = req_wide ? `HSTRP_EC_SMC_WIDE : `HSTRP_EC_SMC_NARROW;
                if (req_el == hstrp_pkg::HSTRP_EL_USER) begin
                    undef = 1'b1;
                end else if (kernel) begin
                    if (!req_wide && req_cond_fail) begin
                        trap = tsc_eff && hyp_en && COND_FAIL_TRAP;
                    end else if (EL3_IMPL) begin
                        trap = tsc_eff && hyp_en;
                        undef = !trap && s_reg.cfg[`HSTRP_CFG_SMD];
                    end else if (NV_FEAT && s_reg.cfg[`HSTRP_CFG_NV]
                                 && req_wide) begin
                        trap = tsc_eff && hyp_en;
                        undef = !trap;
                    end else begin
                        trap = tsc_eff && hyp_en && NOEL3_TRAP;
                        undef = !trap;
                    end
                end
            end
            hstrp_pkg::HSTRP_K_SYSREG_READ: begin
                ec = `HSTRP_EC_SYSREG;
                in_space = req_wide && (req_op0 == `HSTRP_ID_OP0)
                    && (req_op1 == 3'h0) && (req_crn == 4'h0)
                    && (req_crm >= `HSTRP_ID_WIDE_CRM_LO)
                    && (req_crm <= `HSTRP_ID_CRM_HI);
                trap = kernel && in_space && hit && id_group3_trap_bit_eff && hyp_en;
            end
            hstrp_pkg::HSTRP_K_CP_READ: begin
                ec = `HSTRP_EC_CP15;
                in_space = !req_wide && (req_coproc == `HSTRP_ID_CP)
                    && (req_op1 == 3'h0) && (req_crn == 4'h0)
                    && (req_crm >= `HSTRP_ID_NARROW_CRM_LO)
                    && (req_crm <= `HSTRP_ID_CRM_HI);
                trap = kernel && in_space && hit && id_group3_trap_bit_eff && hyp_en;
            end
            hstrp_pkg::HSTRP_K_FP_READ: begin
                ec = `HSTRP_EC_FP_ID;
                trap = kernel && !req_wide && req_fp_feature
                    && !req_cp_trap && id_group3_trap_bit_eff && hyp_en;
            end
            default: begin
                trap = 1'b0;
            end
        endcase
        if (!trap) begin
            ec = `HSTRP_EC_NONE;
        end

        // Result is one cycle behind the request
        s_next.res_valid = req_valid;
        s_next.res_trap = req_valid && trap;
        s_next.res_undef = req_valid && undef;
        s_next.res_ec = req_valid ? ec : `HSTRP_EC_NONE;
        s_next.res_allow = req_valid && !trap && !undef;
        s_next.res_ret_at_instr = req_valid && trap;
        if (req_valid && trap) begin
            s_next.trap_cnt = s_reg.trap_cnt + 16'h0001;
        end

        // ************************************************************
        // AXI4-Lite slave
        // ************************************************************
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        merged = s_reg.cfg;
        for (int i = 0; i < 4; i++) begin
            if (s_reg.wstrb[i]) begin
                merged[i*8 +: 8] = s_reg.wdata[i*8 +: 8];
            end
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            if (s_reg.awaddr[31:2] == `HSTRP_OFS_CFG >> 2) begin
                // Bits without a function stay zero
                s_next.cfg = merged & `HSTRP_CFG_MASK;
                s_next.bresp = `HSTRP_RESP_OKAY;
            end else if (s_reg.awaddr[31:2] == `HSTRP_OFS_STATUS >> 2) begin
                s_next.bresp = `HSTRP_RESP_OKAY;
            end else begin
                s_next.bresp = `HSTRP_RESP_SLVERR;
            end
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        status = 32'h0000_0000;
        status[`HSTRP_ST_EC_LSB +: 6] = s_reg.res_ec;
        status[`HSTRP_ST_TRAP] = s_reg.res_trap;
        status[`HSTRP_ST_UNDEF] = s_reg.res_undef;
        status[`HSTRP_ST_CNT_LSB +: 16] = s_reg.trap_cnt;
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            if (s_axi_araddr[31:2] == `HSTRP_OFS_CFG >> 2) begin
                s_next.rdata = s_reg.cfg;
                s_next.rresp = `HSTRP_RESP_OKAY;
            end else if (s_axi_araddr[31:2] == `HSTRP_OFS_STATUS >> 2) begin
                s_next.rdata = status;
                s_next.rresp = `HSTRP_RESP_OKAY;
            end else begin
                s_next.rdata = 32'h0000_0000;
                s_next.rresp = `HSTRP_RESP_SLVERR;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.cfg <= `HSTRP_CFG_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Ready waits for the response slot so one write is in flight
    assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign res_valid = s_reg.res_valid;
    assign res_trap = s_reg.res_trap;
    assign res_undef = s_reg.res_undef;
    assign res_allow = s_reg.res_allow;
    assign res_ret_at_instr = s_reg.res_ret_at_instr;
    assign res_ec = s_reg.res_ec;

endmodule

// file: core/hstrp_defines.svh
`ifndef HSTRP_DEFINES_SVH
`define HSTRP_DEFINES_SVH

// Register offsets (byte addresses)
`define HSTRP_OFS_CFG 32'h0000_0000
`define HSTRP_OFS_STATUS 32'h0000_0004

// Configuration word layout
`define HSTRP_CFG_HYP_EN 0
`define HSTRP_CFG_NV 1
`define HSTRP_CFG_SMD 2
`define HSTRP_CFG_ID_GROUP3_TRAP_BIT 18
`define HSTRP_CFG_TSC 19
`define HSTRP_CFG_TGE 27
`define HSTRP_CFG_MASK 32'h080C_0007
`define HSTRP_CFG_RESET 32'h0000_0000

// Status word layout
`define HSTRP_ST_EC_LSB 0
`define HSTRP_ST_TRAP 8
`define HSTRP_ST_UNDEF 9
`define HSTRP_ST_CNT_LSB 16

// Exception class codes
`define HSTRP_EC_SMC_WIDE 6'h17
`define HSTRP_EC_SMC_NARROW 6'h13
`define HSTRP_EC_SYSREG 6'h18
`define HSTRP_EC_FP_ID 6'h08
`define HSTRP_EC_CP15 6'h03
`define HSTRP_EC_NONE 6'h00

// Identification encoding space
`define HSTRP_ID_OP0 2'h3
`define HSTRP_ID_CP 4'hF
`define HSTRP_ID_WIDE_CRM_LO 4'h1
`define HSTRP_ID_NARROW_CRM_LO 4'h2
`define HSTRP_ID_CRM_HI 4'h7

// AXI responses
`define HSTRP_RESP_OKAY 2'h0
`define HSTRP_RESP_SLVERR 2'h2

`endif

// file: core/hstrp_pkg.sv
package hstrp_pkg;

    typedef enum logic [1:0] {
        HSTRP_EL_USER,
        HSTRP_EL_KERNEL,
        HSTRP_EL_HYP,
        HSTRP_EL_MON
    } hstrp_el_e;

    typedef enum logic [2:0] {
        HSTRP_K_OTHER,
        HSTRP_K_SMC,
        HSTRP_K_SYSREG_READ,
        HSTRP_K_CP_READ,
        HSTRP_K_FP_READ
    } hstrp_kind_e;

    typedef enum logic [1:0] {
        HSTRP_ID_LISTED,
        HSTRP_ID_NEWER,
        HSTRP_ID_UNLISTED
    } hstrp_idcls_e;

    typedef struct packed {
        logic [31:0] cfg;
        logic aw_got;
        logic [31:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic res_valid;
        logic res_trap;
        logic res_undef;
        logic res_allow;
        logic res_ret_at_instr;
        logic [5:0] res_ec;
        logic [15:0] trap_cnt;
    } hstrp_state_s;

endpackage

// file: sim/hstrp_asserts.sv
`timescale 1ns/1ps
// ****
// Decision checker
// ****
module hstrp_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request side
    input wire logic req_valid,
    input hstrp_pkg::hstrp_kind_e req_kind,
    input hstrp_pkg::hstrp_el_e req_el,
    input wire logic req_wide,
    input wire logic req_cp_trap,
    // Decision side
    input wire logic res_valid,
    input wire logic res_trap,
    input wire logic res_undef,
    input wire logic res_allow,
    input wire logic res_ret_at_instr,
    input wire logic [5:0] res_ec
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_resp_one_cycle: assert property (req_valid |=> res_valid)
        else $error("decision late");
    a_one_outcome: assert property (
        res_valid |-> $onehot({res_trap, res_undef, res_allow}))
        else $error("outcome not unique");
    a_ec_only_trap: assert property (!res_trap |-> res_ec == 6'h00)
        else $error("code without trap");
    a_ret_at_instr: assert property (
        res_valid |-> res_ret_at_instr == res_trap)
        else $error("return point wrong");
    a_user_smc_undef: assert property (req_valid &&
        req_kind == hstrp_pkg::HSTRP_K_SMC &&
        req_el == hstrp_pkg::HSTRP_EL_USER |=> res_undef)
        else $error("user call not undefined");
    a_trap_kernel: assert property (
        res_trap |-> $past(req_el) == hstrp_pkg::HSTRP_EL_KERNEL)
        else $error("trap outside kernel");
    a_smc_code: assert property (
        res_trap && $past(req_kind) == hstrp_pkg::HSTRP_K_SMC |->
        res_ec == ($past(req_wide) ? 6'h17 : 6'h13))
        else $error("monitor call code wrong");
    a_fp_code: assert property (
        res_trap && $past(req_kind) == hstrp_pkg::HSTRP_K_FP_READ |->
        res_ec == 6'h08 && !$past(req_cp_trap))
        else $error("fp read trap wrong");
    c_smc_trap: cover property (res_trap && res_ec == 6'h17);
    c_id_trap: cover property (res_trap && res_ec == 6'h03);
    c_undef: cover property (res_undef);
endmodule

bind hstrp_core hstrp_asserts hstrp_asserts_i (.aclk, .aresetn,
    .req_valid, .req_kind, .req_el, .req_wide, .req_cp_trap, .res_valid,
    .res_trap, .res_undef, .res_allow, .res_ret_at_instr, .res_ec);

// file: sim/hstrp_entry_model.sv
`timescale 1ns/1ps
// ****
// Exception entry model
// ****
module hstrp_entry_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Decision from trap logic
    input wire logic res_valid,
    input wire logic res_trap,
    input wire logic res_allow,
    // Tallies
    output logic [15:0] retired,
    output logic [15:0] trapped
);
    // only allowed retire
    // A trapped instruction never retires, so its effect never lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retired <= 16'h0000;
            trapped <= 16'h0000;
        end else begin
            retired <= retired + 16'(res_valid && res_allow);
            trapped <= trapped + 16'(res_valid && res_trap);
        end
    end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
// ****
// Trap decision bench
// ****
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
    logic awready, wready, arready, bvalid, rvalid, req_valid;
    logic res_valid, res_trap, res_undef, res_allow, res_ret_at_instr;
    logic [31:0] awaddr, wdata, araddr, rdata, q_reg, cfg, d, q;
    logic [1:0] bresp, rresp, r;
    logic [5:0] res_ec;
    logic [8:0] e;
    logic [15:0] retired, trapped, nallow, ntrap;
    int miscompares, total_checks, i, j;

    hstrp_core hstrp_core_i (
        .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .req_valid,
        .req_kind(hstrp_pkg::hstrp_kind_e'(q_reg[2:0])),
        .req_el(hstrp_pkg::hstrp_el_e'(q_reg[4:3])), .req_wide(q_reg[5]),
        .req_cond_fail(q_reg[6]), .req_op0(q_reg[8:7]),
        .req_op1(q_reg[11:9]), .req_crn(q_reg[15:12]),
        .req_crm(q_reg[19:16]), .req_coproc(q_reg[23:20]),
        .req_id_class(hstrp_pkg::hstrp_idcls_e'(q_reg[25:24])),
        .req_raz(q_reg[26]), .req_fp_feature(q_reg[27]),
        .req_cp_trap(q_reg[28]), .res_valid, .res_trap, .res_undef,
        .res_allow, .res_ret_at_instr, .res_ec
    );

    hstrp_entry_model hstrp_entry_model_i (
        .aclk, .aresetn, .res_valid, .res_trap, .res_allow, .retired,
        .trapped
    );

    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic cmp_dec(input logic [10:0] g, input logic [10:0] x);
        cmp_reg({21'h0, g}, {21'h0, x});
    endtask

    // Bounded waits; bready and rready stay high throughout
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
        int n;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (bvalid) break;
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end
        if (n == 40) begin
            miscompares++;
            conclude();
        end
        r = bresp;
    endtask

    task automatic axi_rd(input logic [31:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (rvalid) break;
            arvalid <= arvalid && !arready;
        end
        if (n == 40) begin
            miscompares++;
            conclude();
        end
        d = rdata;
        r = rresp;
    endtask

    // Returns {trap, undef, allow, code}
    function automatic logic [8:0] expect_res(logic [31:0] c, logic [31:0] v);
        logic hk, tid;
        hk = c[0] && v[4:3] == 2'h1 && !c[27];
        tid = c[18] && hk && v[25:24] != 2'h2 && v[15:9] == 7'h00;
        case (v[2:0])
            3'h1: begin
                if (v[4:3] == 2'h0) return 9'h080;
                if (v[4:3] != 2'h1 || v[6]) return 9'h040;
                if (c[19] && hk) return {3'h4, v[5] ? 6'h17 : 6'h13};
                return c[2] ? 9'h080 : 9'h040;
            end
            3'h2: if (tid && v[8:7] == 2'h3 && v[19:16] inside {[1:7]})
                return 9'h118;
            3'h3: if (tid && v[23:20] == 4'hF && v[19:16] inside {[2:7]})
                return 9'h103;
            3'h4: if (c[18] && hk && v[27] && !v[28]) return 9'h108;
            default: return 9'h040;
        endcase
        return 9'h040;
    endfunction

    // First four of a burst are kernel requests, one of each kind from SMC to FP read
    function automatic logic [31:0] gen(int k);
        logic [31:0] v;
        v = $urandom;
        v[2:0] = (k < 4) ? 3'(k + 1) : 3'($urandom_range(0, 4));
        if (k < 4) v[4:3] = 2'h1;
        if (v[7]) v[15:9] = 7'h00;
        if (v[8]) v[19] = 1'b0;
        if (v[29]) v[23:20] = 4'hF;
        if (&v[25:24]) v[24] = 1'b0;
        if (v[2:0] == 3'h2) v[5] = 1'b1;
        if (v[2:0] > 3'h2) v[5] = 1'b0;
        if (v[2:0] != 3'h1 || v[4:3] != 2'h1 || v[5]) v[6] = 1'b0;
        return v;
    endfunction

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, req_valid} = 5'h00;
        {bready, rready} = 2'h3;
        {awaddr, wdata, araddr, q_reg} = 128'h0;
        {miscompares, total_checks, nallow, ntrap} = 0;
        i = $urandom(17);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(32'h0);
        cmp_reg(d, 32'h0);
        axi_wr(32'h8, 32'hFFFF_FFFF);
        cmp_reg({30'h0, r}, 32'h2);
        axi_rd(32'h8);
        cmp_reg({d[29:0], r}, 32'h2);
        for (i = 0; i < 64; i++) begin
            q = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            q = (i == 1) ? 32'h000C_0001 : q;
            axi_wr(32'h0, q);
            cfg = q & 32'h080C_0007;
            axi_rd(32'h0);
            cmp_reg(d, cfg);
            for (j = 0; j <= 32; j++) begin
                @(posedge aclk);
                q = gen(j);
                req_valid <= (j < 32);
                q_reg <= q;
                #1;
                if (j > 0) begin
                    cmp_dec({res_valid, res_trap, res_undef, res_allow,
                        res_ret_at_instr, res_ec},
                        {1'b1, e[8:6], e[8], e[5:0]});
                    ntrap += 16'(e[8]);
                    nallow += 16'(e[6]);
                end
                e = expect_res(cfg, q);
            end
        end
        axi_rd(32'h4);
        cmp_reg(d, {ntrap, 16'h0000});
        cmp_reg({retired, trapped}, {nallow, ntrap});
        conclude();
    end
endmodule
